// file: design/configurable_fault_status.sv
// configurable fault cause register with apb slave and trap control
// assumes core event strobes are one-cycle pulses synchronous to ref_clk
`timescale 1ns/10ps
// Functional notes
// RULE1: set divide-zero flag bit 25 on divide by zero while trapping enabled
// RULE2: divide trapping only when control enable set; else flag stays clear
// RULE3: set misaligned flag bit 24 on unaligned access when trapping enabled
// RULE4: unaligned multiple or doubleword transfers always set misaligned flag
// RULE5: set missing-coprocessor flag bit 19 on coprocessor access fault
// RULE6: set bad-return-load flag bit 18 on illegal return code load
// RULE7: set illegal-state flag bit 17, not when undefined instruction caused it
// RULE8: set unknown-opcode flag bit 16 on undecodable instruction
// RULE9: set bus address valid bit 15 on addressed bus fault; later faults clear
// RULE10: hard fault software clears bus address valid after escalation
// RULE11: set bus-fault-on-push bit 12 on stacking bus fault, no address
// RULE12: set bus-fault-on-pop bit 11 on unstacking bus fault, no address
// RULE13: set deferred data bus error bit 10, no address captured
// RULE14: set precise data bus error bit 9, address captured
// RULE15: set fetch bus error bit 8 only when faulting instruction issues
// RULE16: bit 7 is memory fault address valid, one only while address valid
// RULE17: hard fault software clears memory address valid after escalation
// RULE18: set access-violation-on-push bit 4 on stacking violation
// RULE19: set access-violation-on-pop bit 3 on unstacking violation
// RULE20: all flags reset to zero, cleared only by writing one; bits 15 and 7 also clear on the invalidation strobes
// RULE21: reserved bits read-only zero; software preserves them
// RULE22: usage bits 31:16, bus bits 15:8, memory bits 7:0
// RULE23: word at 0xD28, byte at 0xD29, halfword at 0xD2A via strobes
// RULE24: flags sticky; simultaneous set and clear leaves flag set
// RULE25: writing zero leaves a flag unchanged
module configurable_fault_status (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        divZeroEvt,
   input  wire logic        unalignEvt,
   input  wire logic        unalignMultiEvt,
   input  wire logic        coprocEvt,
   input  wire logic        badReturnEvt,
   input  wire logic        badStateEvt,
   input  wire logic        undefInstrEvt,
   input  wire logic        busPushEvt,
   input  wire logic        busPopEvt,
   input  wire logic        deferBusEvt,
   input  wire logic        precBusEvt,
   input  wire logic        fetchBusIssueEvt,
   input  wire logic        memPushEvt,
   input  wire logic        memPopEvt,
   input  wire logic        dataAvEvt,
   input  wire logic        instrAvEvt,
   input  wire logic        memAddrCapEvt,
   input  wire logic        busAddrInvalEvt,
   input  wire logic        memAddrInvalEvt,
   output logic             divZeroTrapEn,
   output logic             unalignTrapEn,
   output logic [31:0]      causeFlags
);
   logic [31:0] ctrl_ff;
   logic [31:0] nxt_ctrl;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic        err_ff;
   logic        nxt_err;
   logic [31:0] setBits;
   logic [31:0] clrBits;
   logic [31:0] flagBits;
   logic        access;
   logic        hitCause;
   logic        hitCtrl;
   logic        wrCause;

   assign access   = psel && penable;
   assign wrCause  = access && pwrite && hitCause;

   // word-aligned decode; strobes pick the subfield bytes [RULE23]
   always_comb begin
      hitCause = 1'b0;
      hitCtrl  = 1'b0;
      if (paddr[11:2] == fault_cause_pkg::CAUSE_OFFSET[11:2]) begin
         hitCause = 1'b1;
      end else if (paddr[11:2] == fault_cause_pkg::CTRL_OFFSET[11:2]) begin
         hitCtrl = 1'b1;
      end
   end

   assign divZeroTrapEn = ctrl_ff[fault_cause_pkg::CTRL_DIVIDE_ZERO_FLAG_TRAP_BIT];
   assign unalignTrapEn = ctrl_ff[fault_cause_pkg::CTRL_MISALIGNED_ACCESS_FLAG_TRAP_BIT];

   always_comb begin
      setBits = 32'h0000_0000;
      setBits[fault_cause_pkg::DIV_ZERO_BIT]   = divZeroEvt && divZeroTrapEn; // [RULE1] [RULE2]
      // multiple and doubleword forms trap regardless of enable [RULE3] [RULE4]
      setBits[fault_cause_pkg::MISALIGN_BIT]   = (unalignEvt && unalignTrapEn) || unalignMultiEvt;
      setBits[fault_cause_pkg::NO_COPROC_BIT]  = coprocEvt; // [RULE5]
      setBits[fault_cause_pkg::BAD_RET_BIT]    = badReturnEvt; // [RULE6]
      // undefined instruction takes precedence over state misuse [RULE7]
      setBits[fault_cause_pkg::BAD_STATE_BIT]  = badStateEvt && !undefInstrEvt;
      setBits[fault_cause_pkg::UNK_OPCODE_BIT] = undefInstrEvt; // [RULE8]
      setBits[fault_cause_pkg::BUS_AV_BIT]     = precBusEvt; // [RULE9] [RULE14]
      setBits[fault_cause_pkg::BUS_PUSH_BIT]   = busPushEvt; // [RULE11]
      setBits[fault_cause_pkg::BUS_POP_BIT]    = busPopEvt; // [RULE12]
      setBits[fault_cause_pkg::DEFER_BUS_BIT]  = deferBusEvt; // [RULE13]
      setBits[fault_cause_pkg::PREC_BUS_BIT]   = precBusEvt; // [RULE14]
      setBits[fault_cause_pkg::FETCH_BUS_BIT]  = fetchBusIssueEvt; // [RULE15]
      // address valid sets on the capture strobe from the address register or on a data access violation [RULE16]
      setBits[fault_cause_pkg::MEM_AV_BIT]     = memAddrCapEvt || dataAvEvt;
      setBits[fault_cause_pkg::MEM_PUSH_BIT]   = memPushEvt; // [RULE18]
      setBits[fault_cause_pkg::MEM_POP_BIT]    = memPopEvt; // [RULE19]
      setBits[fault_cause_pkg::DATA_AV_BIT]    = dataAvEvt;
      setBits[fault_cause_pkg::INSTR_AV_BIT]   = instrAvEvt;
   end

   apb_byte_decode u_decode (
      .wrHit   (wrCause),
      .pstrb   (pstrb),
      .pwdata  (pwdata),
      .clrBits (clrBits)
   );

   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_flag
         if (fault_cause_pkg::CAUSE_IMPL_MASK[g]) begin : g_impl
            logic clrThis;
            always_comb begin
               clrThis = clrBits[g];
               // a later fault overwrites the address, dropping its valid bit [RULE9]
               if (g == fault_cause_pkg::BUS_AV_BIT) begin
                  clrThis = clrBits[g] || busAddrInvalEvt;
               end else if (g == fault_cause_pkg::MEM_AV_BIT) begin
                  clrThis = clrBits[g] || memAddrInvalEvt; // [RULE16]
               end
            end
            sticky_w1c_bit u_bit (
               .ref_clk  (ref_clk),
               .rst_n    (rst_n),
               .setPulse (setBits[g]),
               .clrPulse (clrThis),
               .flag     (flagBits[g])
            ); // [RULE20] [RULE24]
         end else begin : g_rsvd
            assign flagBits[g] = 1'b0; // [RULE21]
         end
      end
   endgenerate

   // subfields are plain byte lanes of one word [RULE22]
   assign causeFlags = flagBits;

   always_comb begin
      nxt_ctrl  = ctrl_ff;
      nxt_rdata = rdata_ff;
      nxt_err   = err_ff;
      // capture in setup so the access cycle shows settled flop data
      if (psel && !penable) begin
         if (hitCause) begin
            nxt_rdata = flagBits & fault_cause_pkg::CAUSE_IMPL_MASK; // [RULE21]
            nxt_err   = 1'b0;
         end else if (hitCtrl) begin
            nxt_rdata = ctrl_ff;
            nxt_err   = 1'b0;
         end else begin
            // unmapped: error and zero data
            nxt_rdata = 32'h0000_0000;
            nxt_err   = 1'b1;
         end
      end
      if (access && pwrite && hitCtrl) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               nxt_ctrl[b*8 +: 8] = pwdata[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_ff  <= fault_cause_pkg::CTRL_RESET;
         rdata_ff <= fault_cause_pkg::CAUSE_RESET;
         err_ff   <= 1'b0;
      end else begin
         ctrl_ff  <= nxt_ctrl;
         rdata_ff <= nxt_rdata;
         err_ff   <= nxt_err;
      end
   end

   // zero-wait slave: data registered at setup, so an event on the access edge shows next read
   assign pready  = 1'b1;
   assign pslverr = access && err_ff;
   assign prdata  = rdata_ff;
endmodule

// file: design/fault_cause_pkg.sv
// fault cause status block: offsets, bit positions, reset values
// assumes an apb slave decoding byte offsets within the system control space
package fault_cause_pkg;
   localparam logic [11:0] CAUSE_OFFSET      = 12'hD28;
   localparam logic [11:0] CTRL_OFFSET       = 12'hD14;
   localparam logic [31:0] CAUSE_RESET       = 32'h0000_0000;
   localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
   // bits that hardware may set; everything else reads zero
   localparam logic [31:0] CAUSE_IMPL_MASK   = 32'h030F_9F9B;
   localparam int DIV_ZERO_BIT   = 25;
   localparam int MISALIGN_BIT   = 24;
   localparam int NO_COPROC_BIT  = 19;
   localparam int BAD_RET_BIT    = 18;
   localparam int BAD_STATE_BIT  = 17;
   localparam int UNK_OPCODE_BIT = 16;
   localparam int BUS_AV_BIT     = 15;
   localparam int BUS_PUSH_BIT   = 12;
   localparam int BUS_POP_BIT    = 11;
   localparam int DEFER_BUS_BIT  = 10;
   localparam int PREC_BUS_BIT   = 9;
   localparam int FETCH_BUS_BIT  = 8;
   localparam int MEM_AV_BIT     = 7;
   localparam int MEM_PUSH_BIT   = 4;
   localparam int MEM_POP_BIT    = 3;
   localparam int DATA_AV_BIT    = 1;
   localparam int INSTR_AV_BIT   = 0;
   // config control bits steering the trap qualifiers
   localparam int CTRL_DIVIDE_ZERO_FLAG_TRAP_BIT   = 4;
   localparam int CTRL_MISALIGNED_ACCESS_FLAG_TRAP_BIT = 3;
endpackage

// file: design/sticky_w1c_bit.sv
// one sticky flag: hardware sets, software clears by writing one
// assumes set and clear are single-cycle strobes in the ref_clk domain
`timescale 1ns/10ps
module sticky_w1c_bit (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic setPulse,
   input  wire logic clrPulse,
   output logic      flag
);
   logic flag_ff;
   logic nxt_flag;

   always_comb begin
      nxt_flag = flag_ff;
      if (clrPulse) begin
         nxt_flag = 1'b0;
      end
      // set after clear so a same-cycle event is kept [RULE24]
      if (setPulse) begin
         nxt_flag = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag = flag_ff;
endmodule

// file: design/apb_byte_decode.sv
// turns apb write strobes plus data into per-bit write-one-clear pulses
// assumes an apb4 master with pstrb; only acts in the access phase
`timescale 1ns/10ps
module apb_byte_decode (
   input  wire logic        wrHit,
   input  wire logic [3:0]  pstrb,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      clrBits
);
   always_comb begin
      clrBits = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         // a zero bit or a disabled lane leaves the flag alone [RULE25]
         if (wrHit && pstrb[b]) begin
            clrBits[b*8 +: 8] = pwdata[b*8 +: 8];
         end
      end
   end
endmodule

// file: bench/fault_cause_properties.sv
// port assertions for the fault cause block
// assumes it is bound into every instance of the block
`timescale 1ns/10ps
module fault_cause_properties (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        divZeroEvt,
   input wire logic        unalignMultiEvt,
   input wire logic        undefInstrEvt,
   input wire logic        precBusEvt,
   input wire logic        dataAvEvt,
   input wire logic        busAddrInvalEvt,
   input wire logic        memAddrInvalEvt,
   input wire logic        divZeroTrapEn,
   input wire logic [31:0] causeFlags
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic hold;
   // invalidation strobes may drop bits 15 and 7
   assign hold = !(psel && penable && pwrite && pwdata != 32'h0) && !busAddrInvalEvt && !memAddrInvalEvt;
   AST_DIV: assert property (divZeroEvt && divZeroTrapEn |=> causeFlags[25])
      else $error("divide flag missing");
   AST_DIV_OFF: assert property (!divZeroTrapEn && !causeFlags[25] |=> !causeFlags[25])
      else $error("divide flag while untrapped");
   AST_MULTI: assert property (unalignMultiEvt |=> causeFlags[24])
      else $error("misaligned flag missing");
   AST_UNKNOWN_OPCODE_FLAG: assert property (undefInstrEvt && !causeFlags[17] |=> causeFlags[16] && !causeFlags[17])
      else $error("undefined or state flag wrong");
   AST_PRECISE: assert property (precBusEvt |=> causeFlags[9] && causeFlags[15])
      else $error("precise flags missing");
   AST_MEM_VALID: assert property (dataAvEvt |=> causeFlags[7] && causeFlags[1])
      else $error("memory valid missing");
   AST_BUS_INVAL: assert property (busAddrInvalEvt && !precBusEvt |=> !causeFlags[15])
      else $error("bus valid kept");
   AST_STICKY: assert property (hold |=> (causeFlags & $past(causeFlags)) == $past(causeFlags))
      else $error("flag dropped");
   AST_RESERVED: assert property ((causeFlags & 32'hFCF06064) == 32'h0)
      else $error("reserved bit set");
   cover property (psel && penable && pwrite && pwdata != 32'h0);
   cover property (precBusEvt && psel && penable && pwrite);
   cover property (busAddrInvalEvt);
endmodule
bind configurable_fault_status fault_cause_properties chk (.ref_clk, .rst_n, .psel, .penable, .pwrite, .pwdata,
   .divZeroEvt, .unalignMultiEvt, .undefInstrEvt, .precBusEvt, .dataAvEvt, .busAddrInvalEvt, .memAddrInvalEvt,
   .divZeroTrapEn, .causeFlags);

// file: bench/core_event_model.sv
// core stand-in: replays requested fault events as one-cycle pulses
// assumes requests change just after a rising edge
`timescale 1ns/10ps
module core_event_model (
   input  wire logic        ref_clk,
   input  wire logic [18:0] evtReq,
   output logic      [18:0] evt
);
   logic [18:0] evt_ff;
   logic [18:0] nxt_evt;
   always_comb begin
      nxt_evt = evtReq;
   end
   always_ff @(posedge ref_clk) begin
      evt_ff <= nxt_evt;
   end
   assign evt = evt_ff;
endmodule

// file: bench/configurable_fault_status_test.sv
// bench: apb master, core stand-in, checker bound to the block
// assumes zero-wait slave; a flag shows at the edge after its event
`timescale 1ns/10ps
module configurable_fault_status_test;
   localparam logic [11:0] CAUSE = fault_cause_pkg::CAUSE_OFFSET;
   localparam logic [11:0] CTRL  = fault_cause_pkg::CTRL_OFFSET;
   logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr   = 12'h000;
   logic [3:0]  pstrb   = 4'h0;
   logic [18:0] evtReq  = 19'h0, evt;
   logic [31:0] pwdata  = 32'h0, prdata, rdData;
   int          fail_count = 0, checks = 0;
   logic        rdErr, divEn, alignEn;
   logic [31:0] flags;
   logic [31:0] expBits [3:16] = '{32'h80000, 32'h40000, 32'h20000, 32'h10000, 32'h1000, 32'h800, 32'h400,
      32'h8200, 32'h100, 32'h10, 32'h8, 32'h82, 32'h1, 32'h80};
   configurable_fault_status DUT (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .divZeroEvt(evt[0]), .unalignEvt(evt[1]), .unalignMultiEvt(evt[2]), .coprocEvt(evt[3]),
      .badReturnEvt(evt[4]), .badStateEvt(evt[5]), .undefInstrEvt(evt[6]), .busPushEvt(evt[7]), .busPopEvt(evt[8]),
      .deferBusEvt(evt[9]), .precBusEvt(evt[10]), .fetchBusIssueEvt(evt[11]), .memPushEvt(evt[12]),
      .memPopEvt(evt[13]), .dataAvEvt(evt[14]), .instrAvEvt(evt[15]), .memAddrCapEvt(evt[16]),
      .busAddrInvalEvt(evt[17]), .memAddrInvalEvt(evt[18]), .divZeroTrapEn(divEn), .unalignTrapEn(alignEn),
      .causeFlags(flags));
   core_event_model core (.ref_clk, .evtReq, .evt);
   always #12.5 ref_clk = ~ref_clk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ev rides the setup cycle so the model pulses it during the access cycle
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [18:0] ev);
      {psel, pwrite, paddr, pwdata, pstrb, evtReq} <= {1'b1, w, a, d, s, ev};
      @(posedge ref_clk);
      {penable, evtReq} <= {1'b1, 19'h0};
      @(posedge ref_clk);
      for (int n = 0; n < 20 && pready !== 1'b1; n++)
         @(posedge ref_clk);
      if (pready !== 1'b1) begin
         fail_count++;
         conclude();
      end
      rdData = prdata;
      rdErr  = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge ref_clk);
   endtask
   task automatic rdchk(input string what, input logic [31:0] exp);
      xfer(1'b0, CAUSE, 32'h0, 4'h0, 19'h0);
      check(what, rdData, exp);
   endtask
   task automatic fire(input logic [18:0] ev);
      xfer(1'b0, CTRL, 32'h0, 4'h0, ev);
   endtask
   task automatic test_traps;
      xfer(1'b0, CTRL, 32'h0, 4'h0, 19'h3);
      check("control", rdData, 32'h0);
      check("mapped error", {31'h0, rdErr}, 32'h0);
      check("divide enable off", {31'h0, divEn}, 32'h0);
      rdchk("untrapped", 32'h0);
      fire(19'h4);
      rdchk("multi misaligned", 32'h1000000);
      xfer(1'b1, CTRL, 32'h18, 4'hF, 19'h0);
      check("divide enable", {31'h0, divEn}, 32'h1);
      check("misaligned enable", {31'h0, alignEn}, 32'h1);
      fire(19'h3);
      rdchk("trapped", 32'h3000000);
      $display("test_traps done");
   endtask
   task automatic test_events;
      for (int i = 3; i <= 16; i++) begin
         xfer(1'b1, CAUSE, 32'hFFFFFFFF, 4'hF, 19'h0);
         fire(19'h1 << i);
         rdchk("event", expBits[i]);
      end
      fire(19'h60);
      rdchk("undefined over state", 32'h10080);
      $display("test_events done");
   endtask
   task automatic test_clearing;
      xfer(1'b1, CAUSE, 32'h0, 4'hF, 19'h1448);
      rdchk("zero write", 32'h98290);
      xfer(1'b1, CAUSE + 12'h1, 32'hFFFFFFFF, 4'h2, 19'h0);
      rdchk("bus lane", 32'h90090);
      xfer(1'b1, CAUSE + 12'h2, 32'hFFFFFFFF, 4'hC, 19'h0);
      rdchk("usage lanes", 32'h90);
      // precise event lands on the same edge as the clear of its bits
      xfer(1'b1, CAUSE, 32'hFFFFFFFF, 4'h3, 19'h400);
      rdchk("set beats clear", 32'h8200);
      fire(19'h10000);
      fire(19'h60000);
      rdchk("valid dropped", 32'h200);
      fire(19'h10400);
      xfer(1'b1, CAUSE, 32'h8080, 4'hF, 19'h0);
      rdchk("handler clear", 32'h200);
      xfer(1'b1, 12'h000, 32'hFFFFFFFF, 4'hF, 19'h0);
      check("unmapped error", {31'h0, rdErr}, 32'h1);
      rdchk("unmapped write", 32'h200);
      check("flag port", flags, 32'h200);
      $display("test_clearing done");
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      test_traps();
      test_events();
      test_clearing();
      conclude();
   end
endmodule
